// [src/wqw_cfg.sv]
// Windowed watchdog configuration, phase sequencing and question source.
// Assumes reg_* come from the serial control logic on the same clock.
//
// What this block does
// R01: Window-1 duration is bits 6:0, reset all ones.
// R02: Window-2 duration is bits 6:0, reset all ones.
// R03: Long Window duration is bits 7:0, reset all ones.
// R04: Durations, mode and question settings writable only in Long Window.
// R05: Hold bit keeps Long Window; cleared, leave after interval elapses.
// R06: Host sets hold, and must clear it to leave Long Window.
// R07: Mode bit: 0 trigger, 1 question-and-answer; set in Long Window.
// R08: Return bit finishes current sequence, then re-enters Long Window.
// R09: Feedback field shapes question sequence; question mode only.
// R10: LFSR equation field picks question polynomial; question mode only.
// R11: Seed field, reset 1010b, seeds question generation.
// R12: Host writes three answers in Window-1, final one in Window-2.
// R13: Final answer in Window-1 latches early flag; write 1 clears.
// R14: Protected writes outside Long Window are dropped, value kept.
`timescale 1ns/1ps
module wqw_cfg
    import wqw_pkg::*;
#(
    parameter int WIN_STEP = 32,
    parameter int LW_STEP = 256,
    parameter int TW = 20
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [wqw_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_q,
    output logic in_long_window_q,
    output logic window1_q,
    output logic window2_q,
    output logic qa_mode_q,
    output logic [3:0] question_q,
    output logic [1:0] answer_cnt_q,
    output logic [7:0] answer_byte_q,
    output logic answer_valid_q,
    output logic early_answer_flag_q,
    output logic seq_done_q
);
    import wqw_pkg::*;

    // =====================================================================
    // Storage
    logic [6:0] win1_q;
    logic [6:0] win2_q;
    logic [7:0] longwin_q;
    logic hold_q;
    logic ret_q;
    logic [1:0] fdbk_q;
    logic [1:0] lfsr_q;
    logic [3:0] seed_q;
    wqw_phase_t phase_q;
    wqw_phase_t phase_d;
    logic lw_start_q; // Timer is empty out of reset

    // =====================================================================
    // Address decode
    wire in_long = (phase_q == PH_LONG);
    wire wr_win1 = reg_wr && (reg_addr == ADDR_WIN1);
    wire wr_win2 = reg_wr && (reg_addr == ADDR_WIN2);
    wire wr_lw = reg_wr && (reg_addr == ADDR_LONGWIN);
    wire wr_mode = reg_wr && (reg_addr == ADDR_MODE);
    wire wr_qa = reg_wr && (reg_addr == ADDR_QACFG);
    wire wr_ans = reg_wr && (reg_addr == ADDR_ANSWER);
    wire wr_err = reg_wr && (reg_addr == ADDR_ERRSTAT);
    // R04 Long Window gate
    wire prot_ok = in_long;

    // =====================================================================
    // Window timing
    wire expired;
    wire win_end = (phase_q == PH_WIN2) && expired;
    logic [TW-1:0] load_val;
    // Restart the Long Window interval out of reset and while held
    wire timer_load = (phase_d != phase_q) || (in_long && hold_q) ||
                      lw_start_q;

    // Load value for the phase being entered; widen before the product
    always_comb begin
        case (phase_d)
            PH_WIN1: load_val = TW'(({1'b0, win1_q} + 8'h01) * WIN_STEP);
            PH_WIN2: load_val = TW'(({1'b0, win2_q} + 8'h01) * WIN_STEP);
            default: load_val = TW'(({1'b0, longwin_q} + 9'h001) * LW_STEP);
        endcase
    end

    wqw_timer #(.TW(TW)) wqw_timer_i (
        .clk(clk),
        .rstn(rstn),
        .load(timer_load),
        .load_val(load_val),
        .expired(expired)
    );

    // Phase sequencing; hold restarts the Long Window interval
    always_comb begin
        case (phase_q)
            // R05 hold or leave
            PH_LONG: phase_d = (!hold_q && expired && !lw_start_q) ? PH_WIN1
                                                                   : PH_LONG;
            PH_WIN1: phase_d = expired ? PH_WIN2 : PH_WIN1;
            // R08 return after sequence
            PH_WIN2: phase_d = expired ? (ret_q ? PH_LONG : PH_WIN1)
                                       : PH_WIN2;
            default: phase_d = PH_LONG;
        endcase
    end

    // =====================================================================
    // Question generator
    logic lfsr_fb;
    // R10 equation select
    always_comb begin
        case (lfsr_q)
            2'h0: lfsr_fb = question_q[3] ^ question_q[2];
            2'h1: lfsr_fb = question_q[3] ^ question_q[1];
            2'h2: lfsr_fb = question_q[3] ^ question_q[0];
            default: lfsr_fb = question_q[3] ^ question_q[2] ^ question_q[0];
        endcase
    end
    // R09 feedback mixes one stage back in
    wire q_fb = lfsr_fb ^ (fdbk_q != 2'h0 && question_q[fdbk_q]);
    wire [3:0] q_next = {question_q[2:0], q_fb};
    // R11 seed loaded on each exit from Long Window
    wire q_seed = in_long && (phase_d == PH_WIN1);
    wire q_step = win_end && qa_mode_q;

    // =====================================================================
    // Answer tracking; answers only count inside the windows in Q&A mode
    wire ans_take = wr_ans && qa_mode_q && !in_long;
    wire ans_final = (answer_cnt_q == ANS_CNT_FINAL);
    // R13 early final answer
    wire early_set = ans_take && ans_final && (phase_q == PH_WIN1);
    wire early_clr = wr_err && reg_wdata[EARLY_BIT];
    wire [1:0] ans_cnt_d = win_end ? ANS_CNT_RST :
                           ans_take ? answer_cnt_q - 2'h1 : answer_cnt_q;

    // =====================================================================
    // Read mux; reserved bits read zero
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr)
            ADDR_ANSWER: rd_mux = answer_byte_q;
            ADDR_QCNT: rd_mux = {2'h0, answer_cnt_q, question_q};
            ADDR_WIN1: rd_mux = {1'b0, win1_q};
            ADDR_WIN2: rd_mux = {1'b0, win2_q};
            ADDR_LONGWIN: rd_mux = longwin_q;
            ADDR_MODE: rd_mux = {5'h00, hold_q, qa_mode_q, ret_q};
            ADDR_QACFG: rd_mux = {fdbk_q, lfsr_q, seed_q};
            ADDR_ERRSTAT: rd_mux = {4'h0, early_answer_flag_q, 3'h0};
            default: rd_mux = 8'h00;
        endcase
    end

    // =====================================================================
    // Protected configuration fields
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            win1_q <= WIN_RST;
            win2_q <= WIN_RST;
            longwin_q <= LONGWIN_RST;
            qa_mode_q <= MODE_RST;
            fdbk_q <= 2'h0;
            lfsr_q <= 2'h0;
            seed_q <= SEED_RST;
        end else begin
            // R01 R02 R03 duration fields
            // R14 drop writes outside Long Window
            if (wr_win1 && prot_ok) win1_q <= reg_wdata[6:0];
            if (wr_win2 && prot_ok) win2_q <= reg_wdata[6:0];
            if (wr_lw && prot_ok) longwin_q <= reg_wdata;
            // R07 mode select
            if (wr_mode && prot_ok) qa_mode_q <= reg_wdata[MODE_BIT];
            if (wr_qa && prot_ok) begin
                fdbk_q <= reg_wdata[FDBK_LSB +: 2];
                lfsr_q <= reg_wdata[LFSR_LSB +: 2];
                seed_q <= reg_wdata[3:0];
            end
        end
    end

    // Free control bits, phase and status
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hold_q <= 1'b0;
            ret_q <= 1'b0;
            phase_q <= PH_LONG;
            question_q <= QUESTION_RST;
            answer_cnt_q <= ANS_CNT_RST;
            early_answer_flag_q <= 1'b0;
            lw_start_q <= 1'b1;
        end else begin
            lw_start_q <= 1'b0;
            if (wr_mode) begin
                hold_q <= reg_wdata[HOLD_BIT];
                ret_q <= reg_wdata[RET_BIT];
            end
            phase_q <= phase_d;
            question_q <= q_seed ? seed_q : q_step ? q_next : question_q;
            answer_cnt_q <= ans_cnt_d;
            // R13 set wins over clear
            early_answer_flag_q <= (early_answer_flag_q && !early_clr) ||
                                   early_set;
        end
    end

    // Registered outputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_q <= 8'h00;
            in_long_window_q <= 1'b1;
            window1_q <= 1'b0;
            window2_q <= 1'b0;
            answer_byte_q <= 8'h00;
            answer_valid_q <= 1'b0;
            seq_done_q <= 1'b0;
        end else begin
            if (reg_rd) reg_rdata_q <= rd_mux;
            in_long_window_q <= (phase_d == PH_LONG);
            window1_q <= (phase_d == PH_WIN1);
            window2_q <= (phase_d == PH_WIN2);
            if (wr_ans) answer_byte_q <= reg_wdata;
            answer_valid_q <= ans_take;
            seq_done_q <= win_end;
        end
    end

    // =====================================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    win1_lock_a: assert property (wr_win1 && !in_long // R14
        |=> $stable(win1_q))
        else $error("window1 duration changed outside Long Window");
    win2_write_a: assert property (wr_win2 && in_long // R02
        |=> win2_q == $past(reg_wdata[6:0]))
        else $error("window2 duration write lost");
    lw_write_a: assert property (wr_lw && in_long // R03
        |=> longwin_q == $past(reg_wdata))
        else $error("long window duration write lost");
    mode_lock_a: assert property (wr_mode && !in_long // R07
        |=> $stable(qa_mode_q))
        else $error("mode changed outside Long Window");
    qa_lock_a: assert property (wr_qa && !in_long // R04
        |=> $stable({fdbk_q, lfsr_q, seed_q}))
        else $error("question settings changed outside Long Window");
    hold_stay_a: assert property (in_long && hold_q // R05
        |=> phase_q == PH_LONG)
        else $error("left Long Window while held");
    leave_long_a: assert property (in_long && !hold_q && expired // R05
        && !lw_start_q |=> phase_q == PH_WIN1 ##0 window1_q)
        else $error("did not leave Long Window on expiry");
    return_long_a: assert property (win_end && ret_q // R08
        |=> phase_q == PH_LONG ##0 seq_done_q ##0 in_long_window_q)
        else $error("no return to Long Window after sequence");
    continue_a: assert property (win_end && !ret_q // R08
        |=> phase_q == PH_WIN1)
        else $error("sequence did not restart");
    seed_load_a: assert property (q_seed // R11
        |=> question_q == $past(seed_q))
        else $error("question not seeded");
    trig_hold_a: assert property (win_end && !qa_mode_q // R09
        |=> $stable(question_q))
        else $error("question moved in trigger mode");
    early_set_a: assert property (early_set // R13
        |=> early_answer_flag_q)
        else $error("early answer flag not latched");
    early_clr_a: assert property (early_clr && !early_set // R13
        |=> !early_answer_flag_q)
        else $error("early answer flag not cleared");

    full_seq_c: cover property (in_long ##1 phase_q == PH_WIN1
        ##[1:1000] phase_q == PH_WIN2 ##[1:1000] seq_done_q);
    early_c: cover property (early_set);
    ret_c: cover property (win_end && ret_q);
    locked_wr_c: cover property (wr_win1 && !in_long);

endmodule // wqw_cfg

// [src/wqw_pkg.sv]
// Constants shared by the windowed watchdog configuration block.
// Assumes a byte-wide register port on the device's internal clock.
package wqw_pkg;

    // =====================================================================
    // Register addresses
    localparam int ADDR_W = 16;
    localparam logic [15:0] ADDR_ANSWER = 16'h0401;
    localparam logic [15:0] ADDR_QCNT = 16'h0402;
    localparam logic [15:0] ADDR_WIN1 = 16'h0403;
    localparam logic [15:0] ADDR_WIN2 = 16'h0404;
    localparam logic [15:0] ADDR_LONGWIN = 16'h0405;
    localparam logic [15:0] ADDR_MODE = 16'h0406;
    localparam logic [15:0] ADDR_QACFG = 16'h0407;
    localparam logic [15:0] ADDR_ERRSTAT = 16'h0408;

    // =====================================================================
    // Field positions
    localparam int HOLD_BIT = 2;
    localparam int MODE_BIT = 1;
    localparam int RET_BIT = 0;
    localparam int EARLY_BIT = 3;
    localparam int FDBK_LSB = 6;
    localparam int LFSR_LSB = 4;

    // =====================================================================
    // Reset values
    localparam logic [6:0] WIN_RST = 7'h7f;
    localparam logic [7:0] LONGWIN_RST = 8'hff;
    localparam logic MODE_RST = 1'b1;
    localparam logic [3:0] SEED_RST = 4'ha;
    localparam logic [3:0] QUESTION_RST = 4'hc;
    localparam logic [1:0] ANS_CNT_RST = 2'h3;
    localparam logic [1:0] ANS_CNT_FINAL = 2'h0;

    // =====================================================================
    // Watchdog phases
    typedef enum logic [1:0] {
        PH_LONG = 2'b00,
        PH_WIN1 = 2'b01,
        PH_WIN2 = 2'b10
    } wqw_phase_t;

endpackage

// [src/wqw_timer.sv]
// Down-counter that times one watchdog window.
// Assumes load comes from the phase logic; it stays high while the Long Window is held.
`timescale 1ns/1ps
module wqw_timer #(
    parameter int TW = 20
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic load,
    input wire logic [TW-1:0] load_val,
    output logic expired
);

    logic [TW-1:0] cnt_q;
    logic [TW-1:0] cnt_d;

    // Reload wins over counting; hold at zero
    assign cnt_d = load ? load_val :
                   (cnt_q != '0) ? cnt_q - TW'(1) : cnt_q;
    // Plain zero test; gating with load would loop back through phase_d
    assign expired = (cnt_q == '0);

    // Count register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule // wqw_timer

// [tb/wqw_cfg_tb_top.sv]
// Self-checking bench for the watchdog configuration block.
// Assumes short duration steps so every phase ends within a few hundred
// cycles; the host model drives the register port.
`timescale 1ns/1ps
module wqw_cfg_tb_top;
    import wqw_pkg::*;
    logic clk, rstn, reg_wr, reg_rd, in_long_window_q, window1_q, window2_q;
    logic qa_mode_q, answer_valid_q, early_answer_flag_q, seq_done_q;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata_q, answer_byte_q, v, d;
    logic [3:0] question_q, s;
    logic [1:0] answer_cnt_q;
    logic [15:0] ra [4] = '{ADDR_WIN1, ADDR_WIN2, ADDR_LONGWIN, ADDR_QACFG};
    logic [7:0] rm [4] = '{8'h7f, 8'h7f, 8'hff, 8'hff};
    int errors = 0, num_checks = 0, seed = 44, seq_cnt = 0, n0, j;

    // =====================================================================
    // Clock, design and host
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    wqw_cfg #(.WIN_STEP(1), .LW_STEP(2), .TW(20)) wqw_cfg_i (.clk(clk),
        .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
        .in_long_window_q(in_long_window_q), .window1_q(window1_q),
        .window2_q(window2_q), .qa_mode_q(qa_mode_q),
        .question_q(question_q), .answer_cnt_q(answer_cnt_q),
        .answer_byte_q(answer_byte_q), .answer_valid_q(answer_valid_q),
        .early_answer_flag_q(early_answer_flag_q), .seq_done_q(seq_done_q));
    wqw_host_model wqw_host_model_i (.clk(clk), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q));
    // Counts finished watchdog sequences
    always @(posedge clk) begin
        if (seq_done_q === 1'b1) seq_cnt++;
    end

    // =====================================================================
    // Helpers
    function automatic logic [7:0] rst_val(input int i);
        case (i)
            0: return 8'h3c;
            1, 2: return 8'h7f;
            3: return 8'hff;
            4: return 8'h02;
            default: return 8'h0a;
        endcase
    endfunction
    task automatic final_report();
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] dd);
        wqw_host_model_i.wr(a, dd);
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] dd);
        wqw_host_model_i.rd(a, dd);
    endtask
    // Bounded wait: 0 long window, 1 window-1, 2 window-2
    task automatic wait_sig(input int w);
        int n;
        n = 0;
        while (!(w == 0 ? in_long_window_q === 1'b1 :
                 w == 1 ? window1_q === 1'b1 : window2_q === 1'b1)) begin
            @(negedge clk);
            n++;
            if (n > 5000) begin
                errors++;
                final_report();
            end
        end
    endtask

    // =====================================================================
    // Main sequence
    initial begin
        rstn = 1'b0;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        // reset contents, plus an unmapped address
        for (int i = 0; i < 6; i++) begin
            rd(ADDR_QCNT + 16'(i), v);
            check(v, rst_val(i));
        end
        rd(16'h0400, v);
        check(v, 8'h00);
        $display("test reset done");
        // random writes while held in the long window
        wr(ADDR_MODE, 8'h06);
        for (int k = 0; k < 8; k++) begin
            j = $unsigned($random(seed)) % 4;
            d = 8'($random(seed));
            wr(ra[j], d);
            rd(ra[j], v);
            check(v, d & rm[j]);
        end
        $display("test long window writes done");
        // configure, then release hold to start the sequence
        wr(ADDR_WIN1, 8'h3f);
        wr(ADDR_WIN2, 8'h3f);
        wr(ADDR_LONGWIN, 8'h01);
        s = 4'($random(seed));
        wr(ADDR_QACFG, {4'h0, s});
        wr(ADDR_MODE, 8'h02);
        wait_sig(1);
        check({7'h00, in_long_window_q}, 8'h00);
        check({4'h0, question_q}, {4'h0, s});
        // protected writes outside the long window are dropped
        wr(ADDR_WIN1, 8'h11);
        rd(ADDR_WIN1, v);
        check(v, 8'h3f);
        wr(ADDR_MODE, 8'h00);
        rd(ADDR_MODE, v);
        check(v, 8'h02);
        // all four answers in window-1 set the early flag
        repeat (3) wr(ADDR_ANSWER, 8'($random(seed)));
        rd(ADDR_QCNT, v);
        check(v & 8'h30, 8'h00);
        wr(ADDR_ANSWER, 8'h5a);
        rd(ADDR_QCNT, v);
        check(v & 8'h30, 8'h30);
        check(answer_byte_q, 8'h5a);
        check({7'h00, early_answer_flag_q}, 8'h01);
        wr(ADDR_ERRSTAT, 8'h08);
        rd(ADDR_ERRSTAT, v);
        check(v, 8'h00);
        $display("test answers done");
        // return request with hold set, so the block stays parked
        n0 = seq_cnt;
        wr(ADDR_MODE, 8'h07);
        // three answers in window-1, the final one in window-2
        repeat (3) wr(ADDR_ANSWER, 8'($random(seed)));
        wait_sig(2);
        wr(ADDR_ANSWER, 8'hc3);
        check({7'h00, answer_valid_q}, 8'h01);
        check({7'h00, early_answer_flag_q}, 8'h00);
        wait_sig(0);
        // Let the done pulse reach the sequence counter
        @(negedge clk);
        check(8'(seq_cnt - n0), 8'h01);
        $display("test return done");
        // trigger mode selected in the long window ignores answers
        wr(ADDR_MODE, 8'h04);
        rd(ADDR_MODE, v);
        check(v, 8'h04);
        check({7'h00, qa_mode_q}, 8'h00);
        wr(ADDR_MODE, 8'h00);
        wait_sig(1);
        wr(ADDR_ANSWER, 8'ha5);
        check({7'h00, answer_valid_q}, 8'h00);
        check(answer_byte_q, 8'ha5);
        rd(ADDR_QCNT, v);
        check(v & 8'h30, 8'h30);
        $display("test trigger mode done");
        final_report();
    end
endmodule // wqw_cfg_tb_top

// [tb/wqw_host_model.sv]
// Host controller model for the watchdog register port.
// Assumes the block samples its strobes on the rising clock edge.
`timescale 1ns/1ps
module wqw_host_model
    import wqw_pkg::*;
(
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [wqw_pkg::ADDR_W-1:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_q
);
    // =====================================================================
    // Idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
    end

    // =====================================================================
    // Bus cycles, one strobe cycle each, driven off the falling edge
    // Stale address and data are inverted so they never look valid
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    // Read data is registered, so it is settled by the next falling edge
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata_q;
    endtask
endmodule // wqw_host_model
